// File: pic_cfg.svh
// constants for the pulser input counter
// What this block does
// R1: mode 01 decodes lines A and B as quadrature, counting at 2x.
// R2: mode 11 treats line A and line B as separate up and down trains.
// R3: quadrature: direction bit 0 counts forward when A leads, 1 when B leads.
// R4: separate pulses: forward on rising A when direction is 0, rising B when 1.
// R5: disable bit 31 set ignores lines A and B completely.
// R6: filter bit 27 filters direction switch and pulser enable inputs.
// R7: with the filter on, pulses shorter than the threshold are discarded.
// R8: while waiting for pulser input the state field reads 1000.
// R9: pulser input error flag is readable at bit 17 of the error word.
// R10: a phase A/B input error sets the error flag.
// R11: buffer counter flag is readable at bit 14 of the error word.
// R12: a buffer counter overflow sets the buffer counter flag.
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

`define PIC_CLK_HZ 40000000
`define PIC_MS_PER_S 1000
`define PIC_FILTER_MS 32
`define PIC_BUF_W_DEF 16
`define PIC_ADDR_W 8

// register byte addresses
`define PIC_OFF_ENV1 8'h00
`define PIC_OFF_ENV2 8'h04
`define PIC_OFF_STATE 8'h08
`define PIC_OFF_ERROR 8'h0C
`define PIC_OFF_IRQ_STAT 8'h10
`define PIC_OFF_IRQ_MASK 8'h14
`define PIC_OFF_COUNT 8'h18

// field positions
`define PIC_BIT_FILTER 27
`define PIC_BIT_MODE_LO 24
`define PIC_BIT_MODE_HI 25
`define PIC_BIT_DIR 26
`define PIC_BIT_OFF 31
`define PIC_BIT_ERR_INPUT 17
`define PIC_BIT_ERR_OVF 14
`define PIC_STATE_LO 0
`define PIC_STATE_HI 3

// codes and reset values
`define PIC_MODE_QUAD 2'h1
`define PIC_MODE_SEPARATE 2'h3
`define PIC_STATE_IDLE_CODE 4'h0
`define PIC_STATE_WAIT_CODE 4'h8
`define PIC_EV_ERR 0
`define PIC_EV_OVF 1
`define PIC_EV_CNT 2
`define PIC_EV_N 3
`define PIC_PIN_N 5
`define PIC_PIN_RST 5'h10
`define PIC_RESP_OKAY 2'h0
`define PIC_RESP_SLVERR 2'h2

`endif

// File: pic_pkg.sv
// types shared by the pulser input counter
`default_nettype none
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_ST_IDLE = 2'h0,
    PIC_ST_WAIT = 2'h1
  } pic_state_t;
endpackage
`default_nettype wire

// File: pic_noise_filter.sv
// noise filter for one synchronised input level
`timescale 1ns/1ps
`default_nettype none
module pic_noise_filter #(
  parameter int CNT = 2,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic rawIn,
  output logic filtOut
);
  localparam int CW = $clog2(CNT + 1);

  if (CNT < 1) begin : gChk
    $error("filter length must be at least one cycle");
  end

  logic [CW-1:0] cntQ;

  // a level must hold for CNT cycles before it is passed on
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      filtOut <= RST_VAL;
      cntQ <= '0;
    end else if (!enable || rawIn == filtOut) begin
      filtOut <= enable ? filtOut : rawIn;
      cntQ <= '0;
    end else if (cntQ == CW'(CNT - 1)) begin
      filtOut <= rawIn; // [R7]
      cntQ <= '0;
    end else begin
      cntQ <= cntQ + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: pic_pulser_input_counter.sv
// pulser input counter with axi4-lite registers
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"
module pic_pulser_input_counter #(
  parameter int BUF_W = `PIC_BUF_W_DEF,
  parameter int FILTER_CYCLES =
    `PIC_FILTER_MS * (`PIC_CLK_HZ / `PIC_MS_PER_S)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [`PIC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PIC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pulserLineA,
  input wire logic pulserLineB,
  input wire logic directionSwitchPlus,
  input wire logic directionSwitchMinus,
  input wire logic pulserEnableInputN,
  output logic dirPlusFiltered,
  output logic dirMinusFiltered,
  output logic pulserEnableFilteredN,
  output logic countPulse,
  output logic countForward,
  output logic irq
);

  if (BUF_W < 2 || BUF_W > 32) begin : gChk
    $error("buffer counter width must be 2 to 32");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam logic [`PIC_PIN_N-1:0] PIN_RST = `PIC_PIN_RST;

  logic [`PIC_PIN_N-1:0] pinRaw;
  logic [`PIC_PIN_N-1:0] s1Q;
  logic [`PIC_PIN_N-1:0] s2Q;
  logic [`PIC_PIN_N-1:0] s3Q;
  logic [`PIC_PIN_N-1:0] pinQ;

  assign pinRaw = {
    pulserEnableInputN,
    directionSwitchMinus,
    directionSwitchPlus,
    pulserLineB,
    pulserLineA
  };

  // a level counts only once the second and third stage agree
  for (genvar i = 0; i < `PIC_PIN_N; i++) begin : gSync
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        s1Q[i] <= PIN_RST[i];
        s2Q[i] <= PIN_RST[i];
        s3Q[i] <= PIN_RST[i];
        pinQ[i] <= PIN_RST[i];
      end else begin
        s1Q[i] <= pinRaw[i];
        s2Q[i] <= s1Q[i];
        s3Q[i] <= s2Q[i];
        if (s2Q[i] == s3Q[i]) begin
          pinQ[i] <= s3Q[i];
        end
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic filterOnQ;
  logic [1:0] modeQ;
  logic dirQ;
  logic offQ;
  logic [`PIC_EV_N-1:0] statusQ;
  logic [`PIC_EV_N-1:0] maskQ;

  // ----------------------------------------
  // noise filters on switch and enable inputs
  // ----------------------------------------
  logic [2:0] filtOut;

  for (genvar f = 0; f < 3; f++) begin : gFilt
    pic_noise_filter #(
      .CNT(FILTER_CYCLES),
      .RST_VAL(PIN_RST[f + 2])
    ) uFilt (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .enable(filterOnQ), // [R6]
      .rawIn(pinQ[f + 2]),
      .filtOut(filtOut[f])
    );
  end

  assign dirPlusFiltered = filtOut[0];
  assign dirMinusFiltered = filtOut[1];
  assign pulserEnableFilteredN = filtOut[2];

  // ----------------------------------------
  // operation state
  // ----------------------------------------
  pic_pkg::pic_state_t stateQ;
  logic modeValid;

  assign modeValid = (modeQ == `PIC_MODE_QUAD) ||
                     (modeQ == `PIC_MODE_SEPARATE);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stateQ <= pic_pkg::PIC_ST_IDLE;
    end else begin
      case (stateQ)
        pic_pkg::PIC_ST_IDLE: begin
          if (!offQ && modeValid && !pulserEnableFilteredN) begin
            stateQ <= pic_pkg::PIC_ST_WAIT;
          end
        end
        pic_pkg::PIC_ST_WAIT: begin
          if (offQ || !modeValid || pulserEnableFilteredN) begin
            stateQ <= pic_pkg::PIC_ST_IDLE;
          end
        end
        default: begin
          stateQ <= pic_pkg::PIC_ST_IDLE;
        end
      endcase
    end
  end

  logic [3:0] stateCode;
  assign stateCode = (stateQ == pic_pkg::PIC_ST_WAIT) ?
                     `PIC_STATE_WAIT_CODE : `PIC_STATE_IDLE_CODE; // [R8]

  // ----------------------------------------
  // pulse decoding
  // ----------------------------------------
  logic aPrevQ;
  logic bPrevQ;
  logic aEdge;
  logic bEdge;
  logic step;
  logic fwd;
  logic phaseErr;
  logic accept;

  // edges while not waiting are tracked and dropped, so none is counted later
  assign accept = (stateQ == pic_pkg::PIC_ST_WAIT); // [R5]
  assign aEdge = pinQ[0] != aPrevQ;
  assign bEdge = pinQ[1] != bPrevQ;

  always_comb begin
    step = 1'b0;
    fwd = 1'b0;
    phaseErr = 1'b0;
    if (accept) begin
      case (modeQ)
        `PIC_MODE_QUAD: begin
          // both lines moving at once leaves the direction unknown
          if (aEdge && bEdge) begin
            phaseErr = 1'b1; // [R10]
          end else if (aEdge) begin
            step = 1'b1; // [R1]
            fwd = (pinQ[0] != pinQ[1]) ^ dirQ; // [R3]
          end
        end
        `PIC_MODE_SEPARATE: begin
          if (aEdge && pinQ[0] && bEdge && pinQ[1]) begin
            phaseErr = 1'b1; // [R10]
          end else if (aEdge && pinQ[0]) begin
            step = 1'b1; // [R2]
            fwd = !dirQ; // [R4]
          end else if (bEdge && pinQ[1]) begin
            step = 1'b1; // [R2]
            fwd = dirQ; // [R4]
          end
        end
        default: begin
          step = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aPrevQ <= 1'b0;
      bPrevQ <= 1'b0;
    end else begin // [R5]
      aPrevQ <= pinQ[0];
      bPrevQ <= pinQ[1];
    end
  end

  // ----------------------------------------
  // buffer counter
  // ----------------------------------------
  localparam logic [BUF_W-1:0] CNT_MAX = {1'b0, {(BUF_W-1){1'b1}}};
  localparam logic [BUF_W-1:0] CNT_MIN = {1'b1, {(BUF_W-1){1'b0}}};

  logic [BUF_W-1:0] bufCountQ;
  logic overflow;

  // the counter wraps; software learns of it only through the flag
  assign overflow = step && (fwd ? (bufCountQ == CNT_MAX) :
                                   (bufCountQ == CNT_MIN)); // [R12]

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bufCountQ <= '0;
    end else if (step) begin
      bufCountQ <= fwd ? bufCountQ + 1'b1 : bufCountQ - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      countPulse <= 1'b0;
      countForward <= 1'b0;
    end else begin
      countPulse <= step;
      countForward <= step ? fwd : countForward;
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic awHeldQ;
  logic wHeldQ;
  logic [`PIC_ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  logic [31:0] wMask;

  assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
  assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
  assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;

  for (genvar b = 0; b < 4; b++) begin : gStrb
    assign wMask[b*8 +: 8] = {8{wStrbQ[b]}};
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeldQ <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeldQ <= 1'b1;
      wDataQ <= s_axi_wdata;
      wStrbQ <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeldQ <= 1'b0;
    end
  end

  logic wrMapped;
  always_comb begin
    case (awAddrQ)
      `PIC_OFF_ENV1, `PIC_OFF_ENV2, `PIC_OFF_STATE,
      `PIC_OFF_ERROR, `PIC_OFF_IRQ_STAT, `PIC_OFF_IRQ_MASK,
      `PIC_OFF_COUNT: wrMapped = 1'b1;
      default: wrMapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PIC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] wEff;
  assign wEff = wDataQ & wMask;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      filterOnQ <= 1'b0;
    end else if (doWrite && awAddrQ == `PIC_OFF_ENV1 &&
                 wStrbQ[`PIC_BIT_FILTER / 8]) begin
      filterOnQ <= wDataQ[`PIC_BIT_FILTER]; // [R6]
    end
  end

  // all env2 fields sit in the top byte lane
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      modeQ <= 2'h0;
      dirQ <= 1'b0;
      offQ <= 1'b0;
    end else if (doWrite && awAddrQ == `PIC_OFF_ENV2 &&
                 wStrbQ[`PIC_BIT_OFF / 8]) begin
      modeQ <= wDataQ[`PIC_BIT_MODE_HI:`PIC_BIT_MODE_LO];
      dirQ <= wDataQ[`PIC_BIT_DIR];
      offQ <= wDataQ[`PIC_BIT_OFF]; // [R5]
    end
  end

  // ----------------------------------------
  // event status, mask and interrupt
  // ----------------------------------------
  logic [`PIC_EV_N-1:0] evSet;
  logic [`PIC_EV_N-1:0] evClr;

  assign evSet[`PIC_EV_ERR] = phaseErr; // [R10]
  assign evSet[`PIC_EV_OVF] = overflow; // [R12]
  assign evSet[`PIC_EV_CNT] = step;
  assign evClr = (doWrite && awAddrQ == `PIC_OFF_IRQ_STAT) ?
                 wEff[`PIC_EV_N-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      statusQ <= '0;
    end else begin
      statusQ <= (statusQ & ~evClr) | evSet;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      maskQ <= '0;
    end else if (doWrite && awAddrQ == `PIC_OFF_IRQ_MASK &&
                 wStrbQ[0]) begin
      maskQ <= wDataQ[`PIC_EV_N-1:0];
    end
  end

  assign irq = |(statusQ & maskQ);

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic [31:0] rdMux;
  logic rdMapped;

  always_comb begin
    rdMux = 32'h0;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      `PIC_OFF_ENV1, `PIC_OFF_ENV2: begin
        rdMux = 32'h0;
      end
      `PIC_OFF_STATE: begin
        rdMux[`PIC_STATE_HI:`PIC_STATE_LO] = stateCode; // [R8]
      end
      `PIC_OFF_ERROR: begin
        rdMux[`PIC_BIT_ERR_INPUT] = statusQ[`PIC_EV_ERR]; // [R9]
        rdMux[`PIC_BIT_ERR_OVF] = statusQ[`PIC_EV_OVF]; // [R11]
      end
      `PIC_OFF_IRQ_STAT: begin
        rdMux[`PIC_EV_N-1:0] = statusQ;
      end
      `PIC_OFF_IRQ_MASK: begin
        rdMux[`PIC_EV_N-1:0] = maskQ;
      end
      `PIC_OFF_COUNT: begin
        rdMux = 32'(signed'(bufCountQ));
      end
      default: begin
        rdMapped = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PIC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdMapped ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: pic_chk.sv
// port assertions for the pulser input counter
`timescale 1ns/1ps
`default_nettype none
module pic_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pulserLineA,
  input wire logic pulserLineB,
  input wire logic countPulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence linesQuiet;
    $stable(pulserLineA) && $stable(pulserLineB);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
    else $error("write not answered in two cycles");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_pulse_single: assert property (countPulse |=> !countPulse)
    else $error("count pulse longer than one cycle");
  // sync latency is four cycles, so seven quiet cycles leave nothing in flight
  a_lines_quiet: assert property (linesQuiet [*7] |-> !countPulse)
    else $error("count without a line edge");
endmodule
`default_nettype wire

// File: pic_pulser_model.sv
// partner model: pulse generator driving lines A and B
`timescale 1ns/1ps
`default_nettype none
module pic_pulser_model (
  input wire logic sys_clk,
  output logic pulserLineA,
  output logic pulserLineB
);
  initial begin
    pulserLineA = 1'h0;
    pulserLineB = 1'h0;
  end
  // each level held five cycles so the three-stage synchroniser sees it
  task automatic step(input logic a, input logic b);
    @(posedge sys_clk);
    pulserLineA <= a;
    pulserLineB <= b;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic quad(input int n, input logic aLeads);
    repeat (n) begin
      step(aLeads, !aLeads);
      step(1'h1, 1'h1);
      step(!aLeads, aLeads);
      step(1'h0, 1'h0);
    end
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the pulser input counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic directionSwitchPlus = 1'h0, directionSwitchMinus = 1'h0, pulserEnableInputN = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdData;
  logic pulserLineA, pulserLineB, dirPlusFiltered, dirMinusFiltered, pulserEnableFilteredN;
  logic countPulse, countForward, irq, lastFwd, seen;
  int failures = 0, checks = 0, pulses = 0, cycles = 0;

  always #12.5 sys_clk = ~sys_clk;
  // short counter and filter keep overflow and glitch cases within a few cycles
  pic_pulser_input_counter #(.BUF_W(4), .FILTER_CYCLES(4)) DUT (.*);
  pic_pulser_model PM (.*);

  always @(posedge sys_clk) begin
    cycles++;
    if (countPulse === 1'h1) begin
      pulses++;
      lastFwd = countForward;
    end
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rdData = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    rd(a);
    chk(nm, rdData & m, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    wr(8'h14, 32'h7);
    wr(8'h04, 32'h0100_0000);
    chk("write resp", {30'h0, resp}, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    chk("unmapped write resp", {30'h0, resp}, 32'h2);
    rchk("wait state", 8'h08, 32'hF, 32'h8);
    rd(8'hFC);
    chk("unmapped resp", {30'h0, resp}, 32'h2);
    chk("unmapped data", rdData, 32'h0);
    $display("done: registers");
  endtask
  task automatic t_quad;
    pulses = 0;
    PM.quad(2, 1'h1);
    chk("quad pulses", pulses, 32'h4);
    chk("quad dir a leads", {31'h0, lastFwd}, 32'h1);
    rchk("count up", 8'h18, 32'hFFFF_FFFF, 32'h4);
    wr(8'h04, 32'h0500_0000);
    PM.quad(2, 1'h1);
    chk("quad dir reversed", {31'h0, lastFwd}, 32'h0);
    rchk("count back", 8'h18, 32'hFFFF_FFFF, 32'h0);
    $display("done: quadrature");
  endtask
  task automatic t_sep;
    wr(8'h04, 32'h0300_0000);
    pulses = 0;
    PM.step(1'h1, 1'h0);
    PM.step(1'h0, 1'h0);
    chk("line a up", {31'h0, lastFwd}, 32'h1);
    PM.step(1'h0, 1'h1);
    PM.step(1'h0, 1'h0);
    chk("line b down", {31'h0, lastFwd}, 32'h0);
    wr(8'h04, 32'h0700_0000);
    PM.step(1'h0, 1'h1);
    PM.step(1'h0, 1'h0);
    chk("line b up", {31'h0, lastFwd}, 32'h1);
    chk("rising only", pulses, 32'h3);
    $display("done: separate pulses");
  endtask
  task automatic t_off;
    wr(8'h04, 32'h8100_0000);
    rchk("state off", 8'h08, 32'hF, 32'h0);
    pulses = 0;
    PM.quad(1, 1'h1);
    PM.step(1'h1, 1'h0);
    // an edge made while disabled must not count once input is enabled
    wr(8'h04, 32'h0100_0000);
    PM.step(1'h1, 1'h0);
    chk("ignored pulses", pulses, 32'h0);
    wr(8'h04, 32'h8100_0000);
    PM.step(1'h0, 1'h0);
    rchk("count frozen", 8'h18, 32'hFFFF_FFFF, 32'h1);
    $display("done: disable");
  endtask
  task automatic t_err;
    wr(8'h04, 32'h0100_0000);
    // drop earlier count events so only the error can raise irq
    wr(8'h10, 32'h7);
    pulses = 0;
    PM.step(1'h1, 1'h1);
    PM.step(1'h0, 1'h0);
    chk("no count on error", pulses, 32'h0);
    rchk("input error", 8'h0C, 32'h0002_0000, 32'h0002_0000);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(8'h14, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(8'h10, 32'h7);
    wr(8'h14, 32'h7);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rchk("error cleared", 8'h0C, 32'h0002_0000, 32'h0);
    $display("done: input error");
  endtask
  task automatic t_ovf;
    // from 1, eight forward steps pass 7 and wrap to -7
    PM.quad(4, 1'h1);
    rchk("overflow flag", 8'h0C, 32'h0000_4000, 32'h0000_4000);
    rchk("count wrapped", 8'h18, 32'hFFFF_FFFF, 32'hFFFF_FFF9);
    $display("done: overflow");
  endtask
  task automatic t_filt;
    wr(8'h00, 32'h0800_0000);
    seen = 1'h0;
    @(posedge sys_clk);
    pulserEnableInputN <= 1'h1;
    repeat (2) @(posedge sys_clk);
    pulserEnableInputN <= 1'h0;
    repeat (12) begin
      @(posedge sys_clk);
      if (pulserEnableFilteredN !== 1'h0) seen = 1'h1;
    end
    chk("glitch blocked", {31'h0, seen}, 32'h0);
    pulserEnableInputN <= 1'h1;
    directionSwitchPlus <= 1'h1;
    directionSwitchMinus <= 1'h1;
    repeat (12) @(posedge sys_clk);
    chk("enable passed", {31'h0, pulserEnableFilteredN}, 32'h1);
    chk("plus passed", {31'h0, dirPlusFiltered}, 32'h1);
    chk("minus passed", {31'h0, dirMinusFiltered}, 32'h1);
    $display("done: filter");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    t_regs();
    t_quad();
    t_sep();
    t_off();
    t_err();
    t_ovf();
    t_filt();
    give_verdict();
  end
endmodule

bind pic_pulser_input_counter pic_chk chk (.*);
`default_nettype wire
